// >>> ctu_defines.svh
// How it works
// (RULE_01) Bit 31: first edge edge/level sampling
// (RULE_02) Bit 30: first edge rising or falling
// (RULE_03) Bits 29-26 pick first edge source
// (RULE_04) Bit 25: second edge flag, hardware/software set
// (RULE_05) Bit 24: first edge flag, hardware/software set
// (RULE_06) Bit 23: second edge edge/level sampling
// (RULE_07) Bit 22: second edge rising or falling
// (RULE_08) Bits 21-18 pick second source; 1100 clock
// (RULE_09) Bit 15 turns the unit on
// (RULE_10) Bit 13 stops the unit in idle
// (RULE_11) Bit 12 enables pulse delay generation
// (RULE_12) Software picks comparator two before delay mode
// (RULE_13) Bit 11 gates all edges to flags
// (RULE_14) Software discharges capacitor while converter samples
// (RULE_15) Bits 17-16 and 14 read zero
// (RULE_16) Clear, set, invert aliases at 4, 8, C
// (RULE_17) Bit 10: second edge needs first edge
// (RULE_18) Bit 8 enables the trigger output
// (RULE_19) Bits 7-2: signed current trim
// (RULE_20) Bits 1-0: current range multiplier
// (RULE_21) Current on while first set, second clear
`ifndef CTU_DEFINES_SVH
`define CTU_DEFINES_SVH

// ************************************************************
// Register map
// ************************************************************
`define CTU_CTRL_OFS   16'hA200
`define CTU_CLR_OFS    16'hA204
`define CTU_SET_OFS    16'hA208
`define CTU_INV_OFS    16'hA20C
`define CTU_CTRL_RST   32'h0000_0000
`define CTU_CTRL_WMASK 32'hFFFC_BFFF
`define CTU_RD_ZERO    32'h0000_0000
`define CTU_HRESP_OKAY 1'b0

// ************************************************************
// Control register fields
// ************************************************************
`define CTU_E1_SENS    31
`define CTU_E1_POL     30
`define CTU_E1_SEL_HI  29
`define CTU_E1_SEL_LO  26
`define CTU_E2_FLAG    25
`define CTU_E1_FLAG    24
`define CTU_E2_SENS    23
`define CTU_E2_POL     22
`define CTU_E2_SEL_HI  21
`define CTU_E2_SEL_LO  18
`define CTU_ON         15
`define CTU_SIDL       13
`define CTU_DELAY_GENERATION_ENABLE       12
`define CTU_EDGE_GATE      11
`define CTU_SEQ        10
`define CTU_DISCH      9
`define CTU_TRIG       8
`define CTU_TRIM_HI    7
`define CTU_TRIM_LO    2
`define CTU_RNG_HI     1
`define CTU_RNG_LO     0

// ************************************************************
// Codes
// ************************************************************
`define CTU_SRC_CMP2   4'hE
`define CTU_RNG_BASE   2'h1
`define CTU_RNG_X10    2'h2
`define CTU_RNG_X100   2'h3
`define CTU_RNG_X1000  2'h0
`define CTU_DEC_0      2'h0
`define CTU_DEC_1      2'h1
`define CTU_DEC_2      2'h2
`define CTU_DEC_3      2'h3

`endif

// >>> ctu_pkg.sv
`default_nettype none
package ctu_pkg;

  // Pulse delay sequence, Gray along wait, run, done
  typedef enum logic [1:0] {
    CTU_ST_WAIT = 2'h0,
    CTU_ST_RUN  = 2'h1,
    CTU_ST_DONE = 2'h3
  } ctu_dly_t;

  // Core state
  typedef struct packed {
    logic [31:0] ctrl;
    logic        clk_tog;
    ctu_dly_t    dly;
    logic        cur_en;
    logic        trig;
    logic        ground;
    logic [5:0]  trim;
    logic [1:0]  decade;
  } ctu_core_t;

  // Edge channel state
  typedef struct packed {
    logic prev;
  } ctu_chan_t;

  // Bus slave state
  typedef struct packed {
    logic        dwr;
    logic        drd;
    logic [15:0] daddr;
  } ctu_bus_t;

endpackage
`default_nettype wire

// >>> ctu_ifs.sv
`timescale 1ns/1ps
`default_nettype none
// Edge channel hookup
interface ctu_edge_if;
  logic [15:0] sources;
  logic [3:0]  sel;
  logic        sens;
  logic        pol;
  logic        hit;
  modport chan (input sources, input sel, input sens, input pol, output hit);
  modport core (output sources, output sel, output sens, output pol, input hit);
endinterface

// Bus front end to register file
interface ctu_bus_if;
  logic        wr_en;
  logic [15:0] wr_addr;
  logic [31:0] wr_data;
  logic [31:0] rd_value;
  modport slave (output wr_en, output wr_addr, output wr_data, input rd_value);
  modport core (input wr_en, input wr_addr, input wr_data, output rd_value);
endinterface
`default_nettype wire

// >>> ctu_edge_chan.sv
`timescale 1ns/1ps
`default_nettype none
module ctu_edge_chan
  import ctu_pkg::*;
(
  input  wire logic  hclk,    // Bus clock
  input  wire logic  hresetn, // Async reset, low
  ctu_edge_if.chan   eif      // Source select and hit
);

  ctu_chan_t s_q;
  ctu_chan_t s_d;
  logic      src;

  // Source pick, sensitivity and polarity
  always_comb
  begin
    s_d      = s_q;
    src      = eif.sources[eif.sel];
    s_d.prev = src;
    if (eif.sens)
    begin
      // Edge sensitive: one hit per matching transition
      eif.hit = eif.pol ? (src & ~s_q.prev) : (~src & s_q.prev);
    end
    else
    begin
      // Level sensitive: hit while level equals polarity
      eif.hit = (src == eif.pol);
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

endmodule
`default_nettype wire

// >>> ctu_ahb_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctu_defines.svh"
module ctu_ahb_slave
  import ctu_pkg::*;
(
  input  wire logic        hclk,      // Bus clock
  input  wire logic        hresetn,   // Async reset, low
  input  wire logic        hsel,      // Slave select
  input  wire logic [31:0] haddr,     // Byte address
  input  wire logic [1:0]  htrans,    // Transfer type
  input  wire logic        hwrite,    // Write when high
  input  wire logic [31:0] hwdata,    // Write data
  input  wire logic        hready,    // Bus ready
  output logic             hreadyout, // Always ready
  output logic [31:0]      hrdata,    // Read data
  output logic             hresp,     // Always OKAY
  ctu_bus_if.slave         bif        // Register file side
);

  ctu_bus_t s_q;
  ctu_bus_t s_d;
  logic     take;

  // Zero wait states: the register is a flop, so no stall needed
  always_comb
  begin
    s_d     = s_q;
    take    = hsel & hready & htrans[1];
    s_d.dwr = take & hwrite;
    s_d.drd = take & ~hwrite;
    if (take)
      s_d.daddr = haddr[15:0];
    hreadyout   = 1'b1;
    hresp       = `CTU_HRESP_OKAY;
    bif.wr_en   = s_q.dwr;
    bif.wr_addr = s_q.daddr;
    bif.wr_data = hwdata;
    hrdata      = s_q.drd ? bif.rd_value : `CTU_RD_ZERO;
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

endmodule
`default_nettype wire

// >>> ctu_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctu_defines.svh"
module ctu_top
  import ctu_pkg::*;
(
  input  wire logic        hclk,                    // Bus clock, 125 MHz
  input  wire logic        hresetn,                 // Async reset, low
  input  wire logic        hsel,                    // Slave select
  input  wire logic [31:0] haddr,                   // Byte address
  input  wire logic [1:0]  htrans,                  // Transfer type
  input  wire logic        hwrite,                  // Write when high
  input  wire logic [2:0]  hsize,                   // Word only
  input  wire logic [31:0] hwdata,                  // Write data
  input  wire logic        hready,                  // Bus ready
  output logic             hreadyout,               // Slave ready
  output logic [31:0]      hrdata,                  // Read data
  output logic             hresp,                   // Response
  input  wire logic        comparator_one_output,   // Comparator 1
  input  wire logic        comparator_two_output,   // Comparator 2
  input  wire logic        comparator_three_output, // Comparator 3
  input  wire logic [2:0]  capture_event,           // Capture units 3..1
  input  wire logic [12:0] external_edge_pin,       // Pins 13..1
  input  wire logic        compare_unit_one,        // Compare event
  input  wire logic        first_timer,             // Timer event
  input  wire logic        device_idle,             // Device in idle
  output logic             current_source_enable,   // Current source on
  output logic             current_source_ground,   // Discharge sink on
  output logic             trigger_out,             // Trigger pulse
  output logic             delay_pulse,             // Delay window
  output logic [5:0]       current_trim,            // Signed trim
  output logic [1:0]       current_range,           // Range code
  output logic [1:0]       current_decade           // Decades above base
);

  // ************************************************************
  // Helpers
  // ************************************************************

  // Aliased register write: plain, clear, set or invert
  function automatic logic [31:0] ctu_apply(input logic [31:0] old_v,
                                            input logic [31:0] data,
                                            input logic [15:0] addr);
    logic [31:0] r;
    r = old_v;
    case (addr)
      `CTU_CTRL_OFS: r = data;              // RULE_16
      `CTU_CLR_OFS:  r = old_v & ~data;     // RULE_16
      `CTU_SET_OFS:  r = old_v | data;      // RULE_16
      `CTU_INV_OFS:  r = old_v ^ data;      // RULE_16
      default:       r = old_v;
    endcase
    return r & `CTU_CTRL_WMASK;            // RULE_15
  endfunction

  // Range code to power of ten above base current
  function automatic logic [1:0] ctu_decade(input logic [1:0] rng);
    logic [1:0] d;
    d = `CTU_DEC_0;
    case (rng)
      `CTU_RNG_BASE:  d = `CTU_DEC_0;      // RULE_20
      `CTU_RNG_X10:   d = `CTU_DEC_1;      // RULE_20
      `CTU_RNG_X100:  d = `CTU_DEC_2;      // RULE_20
      `CTU_RNG_X1000: d = `CTU_DEC_3;      // RULE_20
      default:        d = `CTU_DEC_0;
    endcase
    return d;
  endfunction

  // ************************************************************
  // Sub-blocks
  // ************************************************************

  ctu_bus_if  bif ();
  ctu_edge_if e1 ();
  ctu_edge_if e2 ();

  ctu_core_t s_q;
  ctu_core_t s_d;
  logic      active;
  logic      e1_set;
  logic      e2_set;
  logic      hsize_unused;

  // Only word transfers are issued; size carries no meaning here
  assign hsize_unused = ^hsize;

  ctu_ahb_slave u_bus (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .bif       (bif.slave)
  );

  ctu_edge_chan u_edge1 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .eif     (e1.chan)
  );

  ctu_edge_chan u_edge2 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .eif     (e2.chan)
  );

  // ************************************************************
  // Edge source wiring
  // ************************************************************

  // First channel: comparators, captures 3..1, pins 8..3, 1, 2
  assign e1.sources = {comparator_three_output, comparator_two_output,
                       comparator_one_output, capture_event[2:0],
                       external_edge_pin[7:2], external_edge_pin[0],
                       external_edge_pin[1], compare_unit_one, first_timer}; // RULE_03
  assign e1.sel     = s_q.ctrl[`CTU_E1_SEL_HI:`CTU_E1_SEL_LO]; // RULE_03
  assign e1.sens    = s_q.ctrl[`CTU_E1_SENS];                  // RULE_01
  assign e1.pol     = s_q.ctrl[`CTU_E1_POL];                   // RULE_02

  // Second channel: bus clock seen as a toggle, since a clock cannot be sampled as data
  assign e2.sources = {comparator_three_output, comparator_two_output,
                       comparator_one_output, s_q.clk_tog, capture_event[2:0],
                       external_edge_pin[12:8], external_edge_pin[0],
                       external_edge_pin[1], compare_unit_one, first_timer}; // RULE_08
  assign e2.sel     = s_q.ctrl[`CTU_E2_SEL_HI:`CTU_E2_SEL_LO]; // RULE_08
  assign e2.sens    = s_q.ctrl[`CTU_E2_SENS];                  // RULE_06
  assign e2.pol     = s_q.ctrl[`CTU_E2_POL];                   // RULE_07

  // Readback shows live flags; unimplemented bits are held zero
  assign bif.rd_value = (bif.wr_addr == `CTU_CTRL_OFS) ? s_q.ctrl : `CTU_RD_ZERO;

  // ************************************************************
  // Core logic
  // ************************************************************

  // Register file, edge flags, delay sequence and outputs
  always_comb
  begin
    s_d         = s_q;
    s_d.clk_tog = ~s_q.clk_tog;

    // Unit runs when on, unless idle stop is asked and the device idles
    active = s_q.ctrl[`CTU_ON]                                   // RULE_09
             & ~(s_q.ctrl[`CTU_SIDL] & device_idle);             // RULE_10

    // Edges pass only through the gate
    e1_set = active & s_q.ctrl[`CTU_EDGE_GATE] & e1.hit;             // RULE_13
    e2_set = active & s_q.ctrl[`CTU_EDGE_GATE] & e2.hit              // RULE_13
             & (~s_q.ctrl[`CTU_SEQ] | s_q.ctrl[`CTU_E1_FLAG]);   // RULE_17

    // Software write first, so a same-cycle hardware set wins
    if (bif.wr_en)
      s_d.ctrl = ctu_apply(s_q.ctrl, bif.wr_data, bif.wr_addr); // RULE_16
    if (e1_set)
      s_d.ctrl[`CTU_E1_FLAG] = 1'b1;                             // RULE_05
    if (e2_set)
      s_d.ctrl[`CTU_E2_FLAG] = 1'b1;                             // RULE_04

    // Current flows between first and second edge
    s_d.cur_en = active & s_d.ctrl[`CTU_E1_FLAG]
                 & ~s_d.ctrl[`CTU_E2_FLAG];                      // RULE_21
    // Pulse only when the second flag is newly set, not per level hit
    s_d.trig   = s_q.ctrl[`CTU_TRIG] & e2_set                    // RULE_18
                 & ~s_q.ctrl[`CTU_E2_FLAG];
    s_d.ground = s_d.ctrl[`CTU_DISCH];
    s_d.trim   = s_d.ctrl[`CTU_TRIM_HI:`CTU_TRIM_LO];            // RULE_19
    s_d.decade = ctu_decade(s_d.ctrl[`CTU_RNG_HI:`CTU_RNG_LO]);  // RULE_20

    // Pulse delay: window opens on first flag, closes on second
    case (s_q.dly)
      CTU_ST_WAIT:
      begin
        if (active & s_q.ctrl[`CTU_DELAY_GENERATION_ENABLE] & s_d.ctrl[`CTU_E1_FLAG]
            & ~s_d.ctrl[`CTU_E2_FLAG])
          s_d.dly = CTU_ST_RUN;                                  // RULE_11
      end
      CTU_ST_RUN:
      begin
        if (~active | ~s_q.ctrl[`CTU_DELAY_GENERATION_ENABLE] | s_d.ctrl[`CTU_E2_FLAG])
          s_d.dly = CTU_ST_DONE;                                 // RULE_11
      end
      CTU_ST_DONE:
      begin
        // Rearm once software has cleared the first flag
        if (~s_d.ctrl[`CTU_E1_FLAG])
          s_d.dly = CTU_ST_WAIT;
      end
      default:
        s_d.dly = CTU_ST_WAIT;
    endcase
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q      <= '0;
      s_q.ctrl <= `CTU_CTRL_RST;
      s_q.dly  <= CTU_ST_WAIT;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops, except delay_pulse, decoded from the delay state
  assign current_source_enable = s_q.cur_en;
  assign current_source_ground = s_q.ground;
  assign trigger_out           = s_q.trig;
  assign delay_pulse           = (s_q.dly == CTU_ST_RUN);
  assign current_trim          = s_q.trim;
  assign current_range         = s_q.ctrl[`CTU_RNG_HI:`CTU_RNG_LO];
  assign current_decade        = s_q.decade;

endmodule
`default_nettype wire

// >>> ctu_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Trigger source model
// ****
module ctu_src_model (
  input  wire logic        hclk, // Bus clock
  input  wire logic [20:0] act,  // Sources owned by bench
  input  wire logic [20:0] val,  // Their levels
  output logic      [20:0] src   // All trigger sources
);
  logic [20:0] noise_q = 21'h0_0000;
  // Unowned sources toggle, so a wrong select is seen
  always_ff @(posedge hclk)
    noise_q <= ~noise_q;
  assign src = (act & val) | (~act & noise_q);
endmodule
`default_nettype wire

// >>> ctu_top_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctu_defines.svh"
// ****
// Port checker
// ****
module ctu_top_props (
  input wire logic        hclk,                  // Bus clock
  input wire logic        hresetn,               // Reset, low
  input wire logic        hsel,                  // Select
  input wire logic [31:0] haddr,                 // Address
  input wire logic [1:0]  htrans,                // Transfer type
  input wire logic        hwrite,                // Write
  input wire logic        hready,                // Bus ready
  input wire logic        hreadyout,             // Slave ready
  input wire logic [31:0] hrdata,                // Read data
  input wire logic        hresp,                 // Response
  input wire logic        device_idle,           // Idle
  input wire logic        current_source_enable, // Source on
  input wire logic        current_source_ground, // Sink on
  input wire logic        trigger_out,           // Trigger
  input wire logic [5:0]  current_trim,          // Trim
  input wire logic [1:0]  current_range,         // Range
  input wire logic [1:0]  current_decade         // Decade
);
  logic rd_q;
  logic rdc_q;
  // Read data phases; control reads kept apart
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      rd_q  <= 1'b0;
      rdc_q <= 1'b0;
    end
    else
    begin
      rd_q  <= hsel && hready && htrans[1] && !hwrite;
      rdc_q <= hsel && hready && htrans[1] && !hwrite && haddr[15:0] == `CTU_CTRL_OFS;
    end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Live control word on the read bus
  sequence s_ctl_rd;
    rdc_q;
  endsequence
  a_bus_okay: assert property (hreadyout && hresp == `CTU_HRESP_OKAY)
    else $error("bus not ready or not okay");
  a_rdata_idle: assert property (!rd_q |-> hrdata == 32'h0000_0000)
    else $error("read data outside data phase");
  a_rsvd_zero: assert property (rd_q |-> hrdata[17:16] == 2'h0 && !hrdata[14])
    else $error("reserved bits read nonzero");
  a_alias_zero: assert property (rd_q && !rdc_q |-> hrdata == 32'h0000_0000)
    else $error("alias or unmapped read nonzero");
  a_trim_next: assert property (s_ctl_rd |=> current_trim == $past(hrdata[7:2]))
    else $error("trim differs from register");
  a_ground_next: assert property (s_ctl_rd |=> current_source_ground == $past(hrdata[9]))
    else $error("ground differs from register");
  a_source_next: assert property (s_ctl_rd |=> current_source_enable ==
    $past(hrdata[15] && !(hrdata[13] && device_idle) && hrdata[24] && !hrdata[25]))
    else $error("source enable wrong");
  a_decade_map: assert property ($past(hresetn) |-> current_decade == 2'(current_range + 2'h3))
    else $error("decade does not match range");
  a_trig_pulse: assert property (trigger_out |=> !trigger_out)
    else $error("trigger longer than one cycle");
endmodule
bind ctu_top ctu_top_props u_props (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hrdata, .hresp, .device_idle,
  .current_source_enable, .current_source_ground, .trigger_out, .current_trim, .current_range, .current_decade
);
`default_nettype wire

// >>> charge_time_edge_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctu_defines.svh"
module charge_time_edge_control_bench;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, idle = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
  logic [20:0] act = 21'h0_0000, val = 21'h0_0000, src, m1, m2;
  logic [31:0] hrdata, r, c, e;
  logic        rdy, resp, cse, csg, trg, dly;
  logic [5:0]  trim;
  logic [1:0]  rng, dec;
  int          mismatches = 0, checked = 0, tcnt = 0, t0;
  // Source index of each code, first and second channel; 1F is the bus clock
  logic [4:0]  i1 [16] = '{5'h00, 5'h01, 5'h03, 5'h02, 5'h04, 5'h05, 5'h06, 5'h07,
                           5'h08, 5'h09, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14};
  logic [4:0]  i2 [16] = '{5'h00, 5'h01, 5'h03, 5'h02, 5'h0A, 5'h0B, 5'h0C, 5'h0D,
                           5'h0E, 5'h0F, 5'h10, 5'h11, 5'h1F, 5'h12, 5'h13, 5'h14};
  // Free running clock
  always #4 hclk = ~hclk;
  // Count trigger pulses
  always @(posedge hclk)
    if (trg === 1'b1)
      tcnt <= tcnt + 1;
  ctu_src_model SRC (.hclk(hclk), .act(act), .val(val), .src(src));
  ctu_top DUT (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hrdata,
    .hsize(3'h2), .hready(rdy), .hreadyout(rdy), .hresp(resp),
    .comparator_one_output(src[18]), .comparator_two_output(src[19]),
    .comparator_three_output(src[20]), .capture_event(src[17:15]),
    .external_edge_pin(src[14:2]), .compare_unit_one(src[1]), .first_timer(src[0]),
    .device_idle(idle), .current_source_enable(cse), .current_source_ground(csg),
    .trigger_out(trg), .delay_pulse(dly), .current_trim(trim), .current_range(rng),
    .current_decade(dec)
  );
  // ****
  // Bus and check tasks
  // ****
  task automatic wrap_up();
    if (mismatches == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel   <= 1'b1;
    haddr  <= {16'h0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (rdy !== 1'b1 && n++ < 8);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (rdy !== 1'b1 && n++ < 8);
    r = hrdata;
    if (n > 8)
    begin
      mismatches++;
      wrap_up();
    end
  endtask
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic ck(input string s, input logic [15:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(s, r, exp);
  endtask
  // ****
  // Main sequence
  // ****
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ck("reset", `CTU_CTRL_OFS, `CTU_CTRL_RST);
    // Every source code on both channels, level mode
    for (int k = 0; k < 16; k++)
    begin
      m1 = 21'h0_0001 << i1[k];
      m2 = (i2[k] == 5'h1F) ? 21'h0_0000 : 21'h0_0001 << i2[k];
      val <= 21'h0_0000;
      act <= m1 | m2;
      bus(1'b1, `CTU_CTRL_OFS, 32'h0000_0000);
      c = 32'h4040_8800 | (32'(k) << 26) | (32'(k) << 18);
      bus(1'b1, `CTU_CTRL_OFS, c);
      e = c | 32'h0100_0000 | ((m1 == m2 || m2 == 21'h0_0000) ? 32'h0200_0000 : 32'h0000_0000);
      val <= m1;
      repeat (2) @(posedge hclk);
      ck("first flags", `CTU_CTRL_OFS, e);
      val <= m1 | m2;
      repeat (2) @(posedge hclk);
      ck("second flag", `CTU_CTRL_OFS, c | 32'h0300_0000);
    end
    bus(1'b1, `CTU_CTRL_OFS, 32'hFFFF_FFFF);
    ck("mask", `CTU_CTRL_OFS, `CTU_CTRL_WMASK);
    ck("alias read", `CTU_SET_OFS, 32'h0000_0000);
    ck("unmapped", 16'hA210, 32'h0000_0000);
    bus(1'b1, `CTU_CTRL_OFS, 32'h0000_00F0);
    bus(1'b1, `CTU_INV_OFS, 32'h0000_00FF);
    bus(1'b1, `CTU_SET_OFS, 32'h0000_0100);
    bus(1'b1, `CTU_CLR_OFS, 32'h0000_0003);
    ck("alias ops", `CTU_CTRL_OFS, 32'h0000_010C);
    chk("trim", trim, 32'h0000_0003);
    for (int k = 0; k < 4; k++)
    begin
      bus(1'b1, `CTU_CTRL_OFS, 32'(k));
      repeat (2) @(posedge hclk);
      chk("range", rng, 32'(k));
      chk("decade", dec, 32'((k + 3) % 4));
    end
    // Edge mode: falling first edge, rising second edge, trigger on
    act <= 21'h0_0003;
    val <= 21'h0_0000;
    bus(1'b1, `CTU_CTRL_OFS, 32'h80C4_8900);
    repeat (2) @(posedge hclk);
    val <= 21'h0_0001;
    repeat (4) @(posedge hclk);
    ck("rise ignored", `CTU_CTRL_OFS, 32'h80C4_8900);
    t0 = tcnt;
    val <= 21'h0_0000;
    repeat (4) @(posedge hclk);
    chk("source on", cse, 32'h0000_0001);
    val <= 21'h0_0002;
    repeat (4) @(posedge hclk);
    chk("source off", cse, 32'h0000_0000);
    chk("trigger", tcnt - t0, 32'h0000_0001);
    ck("edge flags", `CTU_CTRL_OFS, 32'h83C4_8900);
    // Blocked edges, software flags, unit off, idle stop
    // Compare stays owned: a noisy edge under the old setup would win over the write
    act <= 21'h0_0003;
    val <= 21'h0_0001;
    bus(1'b1, `CTU_CTRL_OFS, 32'h4000_8000);
    repeat (3) @(posedge hclk);
    ck("gate off", `CTU_CTRL_OFS, 32'h4000_8000);
    bus(1'b1, `CTU_SET_OFS, 32'h0300_0000);
    ck("soft flags", `CTU_CTRL_OFS, 32'h4300_8000);
    bus(1'b1, `CTU_CTRL_OFS, 32'h4000_0800);
    repeat (3) @(posedge hclk);
    ck("unit off", `CTU_CTRL_OFS, 32'h4000_0800);
    idle <= 1'b1;
    bus(1'b1, `CTU_CTRL_OFS, 32'h4000_A800);
    repeat (3) @(posedge hclk);
    ck("idle stop", `CTU_CTRL_OFS, 32'h4000_A800);
    idle <= 1'b0;
    repeat (3) @(posedge hclk);
    ck("idle run", `CTU_CTRL_OFS, 32'h4100_A800);
    // Second edge before first must wait
    act <= 21'h0_0003;
    val <= 21'h0_0002;
    // Clear first: a hit under the old setup would win over the write
    bus(1'b1, `CTU_CTRL_OFS, 32'h0000_0000);
    bus(1'b1, `CTU_CTRL_OFS, 32'h4044_8C00);
    repeat (3) @(posedge hclk);
    ck("order hold", `CTU_CTRL_OFS, 32'h4044_8C00);
    val <= 21'h0_0003;
    repeat (3) @(posedge hclk);
    ck("order pass", `CTU_CTRL_OFS, 32'h4344_8C00);
    // Delay window closed by comparator two
    act <= 21'h8_0001;
    val <= 21'h0_0000;
    bus(1'b1, `CTU_CTRL_OFS, 32'h0000_0000);
    bus(1'b1, `CTU_CTRL_OFS, 32'h4078_9800);
    val <= 21'h0_0001;
    repeat (4) @(posedge hclk);
    chk("delay on", dly, 32'h0000_0001);
    val <= 21'h8_0001;
    repeat (4) @(posedge hclk);
    chk("delay off", dly, 32'h0000_0000);
    // Mid-run reset clears flags and outputs
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ck("reset again", `CTU_CTRL_OFS, `CTU_CTRL_RST);
    chk("delay reset", dly, 32'h0000_0000);
    chk("source reset", cse, 32'h0000_0000);
    wrap_up();
  end
endmodule
`default_nettype wire
